// File: rtl/lrp_pkg.sv
// Package holding command encodings, states and timing constants of the refresh/power controller.
package lrp_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 40;
   localparam int REFRESH_CYCLE_TIME_NS = 72;
   localparam int SELF_REFRESH_EXIT_TIME_NS = 112;
   localparam int POWER_DOWN_EXIT_TIME_NS = 25;
   localparam int PRECHARGE_TIME_NS = 15;
   localparam int REFRESH_INTERVAL_NS = 7800;
   localparam int BUS_QUIET_US = 200;
   localparam int MIN_NOP_CYCLES = 2;

   // Least times round up, longest time rounds down, none below one cycle.
   localparam int RFC_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_RAW = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_CYC = (XSR_RAW < MIN_NOP_CYCLES) ? MIN_NOP_CYCLES : XSR_RAW;
   localparam int XP_RAW = (POWER_DOWN_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XP_CYC = (XP_RAW < 1) ? 1 : XP_RAW;
   localparam int RP_RAW = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
   localparam int REFI_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int QUIET_CYC = (BUS_QUIET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_CYC = 1;
   // Cycles from refresh due to the refresh command: precharge, then refresh.
   localparam int REFI_LEAD_CYC = 2;

   // ==========================================================
   // Counters and command pins
   // ==========================================================
   localparam int CNT_W = 16;
   localparam int ADDR_W = 14;
   localparam int ALL_BANKS_BIT = 10;

   // Command pins {cs_n, ras_n, cas_n, we_n}.
   localparam logic [3:0] CMD_DESELECT = 4'hF;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_DEEP_SLEEP = 4'h6;

   typedef enum logic [2:0] {
      LRP_REQ_NONE,
      LRP_REQ_SELF_REFRESH,
      LRP_REQ_POWER_DOWN,
      LRP_REQ_DEEP_SLEEP,
      LRP_REQ_CLOCK_STOP
   } lrp_req_e;

   typedef enum {
      ST_IDLE,
      ST_PRECHARGE,
      ST_PRE_WAIT,
      ST_REFRESH,
      ST_SELF,
      ST_POWER_DOWN,
      ST_DEEP_SLEEP,
      ST_CLK_STOP,
      ST_EXIT_WAIT
   } lrp_state_e;

endpackage

// File: rtl/lrp_down_counter.sv
// Loadable down counter that flags when its count has run out.
`timescale 1ns/10ps

module lrp_down_counter
   import lrp_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control.
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   // Status.
   output logic done
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;

   // Next count: load wins, otherwise step down to zero and hold.
   assign count_nxt = load ? load_value : ((count_r != '0) ? count_r - 1'b1 : count_r);
   assign done = (count_r == '0);

   // Count register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule

// File: rtl/lrp_host_ctrl.sv
// Controller that drives refresh, self refresh, power-down, deep sleep and clock stop of a low-power DRAM.
`timescale 1ns/10ps

// Summary of operation
// - Issue one refresh command per needed refresh.
// - Only NOP or inhibit during refresh cycle.
// - Clock enable high throughout auto refresh.
// - Precharge all banks before refreshing.
// - Refresh encoding with enable low: self refresh.
// - All banks idle before self refresh.
// - Hold enable low to stay self refreshing.
// - Exit: clock runs, enable high, NOP wait.
// - Self refresh never replaces auto refresh.
// - Exit power-down with NOP, wait exit time.
// - No power-down while column access runs.
// - Power-down length bounded by refresh needs.
// - Deep sleep encoding with enable low, idle banks.
// - Deep sleep exit needs full reinitialisation.
// - Data bus kept quiet after deep sleep exit.
// - Frequency change only with timings met.
// - Finish all operations before clock stop.
// - Clock stop: enable high, clock low, complement high.
// - One cycle and NOP after clock restart.
// - Wait precharge time before further bank use.
module lrp_host_ctrl
   import lrp_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // User requests.
   input wire logic [2:0] mode_req,
   input wire logic wake_req,
   input wire logic access_busy,
   // User status.
   output logic idle,
   output logic in_low_power,
   output logic refresh_pulse,
   output logic needs_init,
   output logic bus_quiet_hold,
   // Device pins.
   output logic ck,
   output logic complement_clock,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [ADDR_W-1:0] addr
);

   // ==========================================================
   // State and registers
   // ==========================================================
   // Sequencer state and the pending low-power request.
   lrp_state_e state_r;
   lrp_state_e state_nxt;
   lrp_req_e pending_r;
   lrp_req_e pending_nxt;
   // Pin and status registers.
   logic [3:0] cmd_r;
   logic [3:0] cmd_nxt;
   logic cke_r;
   logic cke_nxt;
   logic clk_run_r;
   logic clk_run_nxt;
   logic ck_r;
   logic ck_nxt;
   logic ck_n_r;
   logic ck_n_nxt;
   logic a10_r;
   logic a10_nxt;
   logic refresh_pulse_r;
   logic needs_init_r;
   logic needs_init_nxt;
   logic in_low_r;
   logic idle_r;
   logic quiet_r;
   // Refresh interval counter.
   logic [CNT_W-1:0] refi_r;
   logic [CNT_W-1:0] refi_nxt;
   // Wait timer load and status.
   logic [CNT_W-1:0] wait_load_value;
   logic wait_load;
   logic wait_done;
   // Quiet-bus counter.
   logic [31:0] quiet_cnt_r;
   logic quiet_start;

   // ==========================================================
   // Request decode
   // ==========================================================
   // The interval counter is loaded short by the lead from due to command, so that
   // refreshes issued from idle land no more than one interval apart.
   wire refresh_due = (refi_r == '0);
   // Codes above clock stop are not modes and are ignored.
   wire lp_req = (mode_req != 3'(LRP_REQ_NONE)) && (mode_req <= 3'(LRP_REQ_CLOCK_STOP));
   // A running column access or burst holds off every low-power entry.
   wire lp_allowed = lp_req && !access_busy;
   // Low-power status follows the state being entered, so the flag and the parked
   // clock change at the same edge.
   wire next_is_lp = (state_nxt == ST_SELF) || (state_nxt == ST_POWER_DOWN) ||
                     (state_nxt == ST_DEEP_SLEEP) || (state_nxt == ST_CLK_STOP);

   // Wait timer shared by precharge, refresh and exit waits.
   // A load of zero finishes in the next cycle, so a one-cycle wait costs nothing extra.
   lrp_down_counter u_wait (
      .clk(clk),
      .rst_n(rst_n),
      .load(wait_load),
      .load_value(wait_load_value),
      .done(wait_done)
   );

   // ==========================================================
   // Sequencer
   // ==========================================================
   // Every command is one cycle wide; a precharge is followed at once by a pending refresh,
   // self refresh or deep sleep command, and every other command by NOP or deselect.
   // The shared wait timer is loaded with one less than the cycles to wait, except for the clock restart, which loads RESTART_CYC,
   // because the state that loads it counts as the first cycle.
   // Next-state logic; each step holds NOP until its timer runs out.
   always_comb begin
      state_nxt = state_r;
      pending_nxt = pending_r;
      cmd_nxt = CMD_NOP;
      cke_nxt = cke_r;
      clk_run_nxt = clk_run_r;
      a10_nxt = 1'b0;
      needs_init_nxt = needs_init_r;
      wait_load = 1'b0;
      wait_load_value = '0;
      refi_nxt = refresh_due ? refi_r : refi_r - 1'b1;
      case (state_r)
         ST_IDLE: begin
            if (refresh_due || lp_allowed) begin
               // Close every row before refresh or any sleep mode.
               pending_nxt = refresh_due ? LRP_REQ_NONE : lrp_req_e'(mode_req);
               cmd_nxt = CMD_PRECHARGE;
               a10_nxt = 1'b1;
               state_nxt = ST_PRE_WAIT;
               wait_load = 1'b1;
               wait_load_value = CNT_W'(RP_CYC - 1);
            end
         end
         // Precharge time has passed: issue what the pending request asked for.
         ST_PRE_WAIT: begin
            if (wait_done) begin
               case (pending_r)
                  // Refresh reloads the interval counter at the command.
                  LRP_REQ_NONE: begin
                     cmd_nxt = CMD_REFRESH;
                     refi_nxt = CNT_W'(REFI_CYC - REFI_LEAD_CYC);
                     state_nxt = ST_REFRESH;
                     wait_load = 1'b1;
                     wait_load_value = CNT_W'(RFC_CYC - 1);
                  end
                  // Refresh encoding with enable low starts self refresh.
                  LRP_REQ_SELF_REFRESH: begin
                     cmd_nxt = CMD_REFRESH;
                     cke_nxt = 1'b0;
                     state_nxt = ST_SELF;
                  end
                  // Enable low with NOP gives precharge power-down, all rows being closed.
                  LRP_REQ_POWER_DOWN: begin
                     cke_nxt = 1'b0;
                     state_nxt = ST_POWER_DOWN;
                  end
                  // Array data is lost here, so the user must run a full init afterwards.
                  LRP_REQ_DEEP_SLEEP: begin
                     cmd_nxt = CMD_DEEP_SLEEP;
                     cke_nxt = 1'b0;
                     needs_init_nxt = 1'b1;
                     state_nxt = ST_DEEP_SLEEP;
                  end
                  // The clock parks low at this edge while enable stays high.
                  LRP_REQ_CLOCK_STOP: begin
                     clk_run_nxt = 1'b0;
                     state_nxt = ST_CLK_STOP;
                  end
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_REFRESH: begin
            // Enable stays high and only NOP goes out during the refresh cycle.
            if (wait_done) begin
               state_nxt = ST_IDLE;
            end
         end
         // The device keeps its data alone; only the enable pin matters here.
         ST_SELF: begin
            cmd_nxt = CMD_DESELECT;
            if (wake_req) begin
               cmd_nxt = CMD_NOP;
               cke_nxt = 1'b1;
               state_nxt = ST_EXIT_WAIT;
               wait_load = 1'b1;
               wait_load_value = CNT_W'(XSR_CYC - 1);
               // Self refresh intervals are unknown, so a refresh follows at once.
               refi_nxt = '0;
            end
         end
         // Power-down is left early when a refresh falls due.
         ST_POWER_DOWN: begin
            cmd_nxt = CMD_DESELECT;
            if (wake_req || refresh_due) begin
               cmd_nxt = CMD_NOP;
               cke_nxt = 1'b1;
               state_nxt = ST_EXIT_WAIT;
               wait_load = 1'b1;
               wait_load_value = CNT_W'(XP_CYC - 1);
            end
         end
         // Deep sleep ignores refresh: the array holds nothing worth keeping.
         ST_DEEP_SLEEP: begin
            cmd_nxt = CMD_DESELECT;
            if (wake_req) begin
               cmd_nxt = CMD_NOP;
               cke_nxt = 1'b1;
               state_nxt = ST_EXIT_WAIT;
               wait_load = 1'b1;
               wait_load_value = CNT_W'(XP_CYC - 1);
            end
         end
         // The restart wait gives one full cycle and NOP before any command.
         ST_CLK_STOP: begin
            cmd_nxt = CMD_DESELECT;
            if (wake_req || refresh_due) begin
               clk_run_nxt = 1'b1;
               state_nxt = ST_EXIT_WAIT;
               wait_load = 1'b1;
               wait_load_value = CNT_W'(RESTART_CYC);
            end
         end
         // NOP holds until the exit time of the mode just left has run.
         ST_EXIT_WAIT: begin
            if (wait_done) begin
               state_nxt = ST_IDLE;
            end
         end
         // Unused state codes fall back to idle.
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Deep sleep exit starts the data bus quiet period.
   // It starts at the wake edge, as the device may drive the data bus from then.
   assign quiet_start = (state_r == ST_DEEP_SLEEP) && wake_req;

   // ==========================================================
   // Flip-flops
   // ==========================================================
   // Sequencer and pin registers.
   // Pins reset to NOP with enable high, a safe state for the device.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         pending_r <= LRP_REQ_NONE;
         cmd_r <= CMD_NOP;
         cke_r <= 1'b1;
         clk_run_r <= 1'b1;
         a10_r <= 1'b0;
         refi_r <= CNT_W'(REFI_CYC - REFI_LEAD_CYC);
         needs_init_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pending_r <= pending_nxt;
         cmd_r <= cmd_nxt;
         cke_r <= cke_nxt;
         clk_run_r <= clk_run_nxt;
         a10_r <= a10_nxt;
         refi_r <= refi_nxt;
         needs_init_r <= needs_init_nxt && !(state_r == ST_IDLE && !wake_req);
      end
   end

   // Device clock: divide by two while running, parked low when stopped.
   // Both phases come from flip-flops so the pair never skews by a gate delay.
   assign ck_nxt = clk_run_nxt ? !ck_r : 1'b0;
   assign ck_n_nxt = clk_run_nxt ? ck_r : 1'b1;

   // Clock pair registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_r <= 1'b0;
         ck_n_r <= 1'b1;
      end else begin
         ck_r <= ck_nxt;
         ck_n_r <= ck_n_nxt;
      end
   end

   // Status registers.
   // Idle and low-power follow the next state, so they change with the pins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_pulse_r <= 1'b0;
         in_low_r <= 1'b0;
         idle_r <= 1'b0;
      end else begin
         refresh_pulse_r <= (cmd_nxt == CMD_REFRESH) && cke_nxt;
         in_low_r <= next_is_lp;
         idle_r <= (state_nxt == ST_IDLE);
      end
   end

   // Quiet-bus counter after deep sleep exit.
   // The hold is counted in system cycles; a slower clock needs a smaller count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_cnt_r <= '0;
         quiet_r <= 1'b0;
      end else begin
         quiet_cnt_r <= quiet_start ? 32'(QUIET_CYCLES) : ((quiet_cnt_r != '0) ? quiet_cnt_r - 1'b1 : quiet_cnt_r);
         quiet_r <= quiet_start || (quiet_cnt_r > 32'h00000001);
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Pins and status come straight from their registers.
   assign {cs_n, ras_n, cas_n, we_n} = cmd_r;
   assign cke = cke_r;
   assign ck = ck_r;
   assign complement_clock = ck_n_r;
   // Only the all-banks bit of the address carries meaning; the rest stay low.
   assign addr = ADDR_W'({a10_r, {ALL_BANKS_BIT{1'b0}}});
   assign refresh_pulse = refresh_pulse_r;
   assign needs_init = needs_init_r;
   assign in_low_power = in_low_r;
   assign idle = idle_r;
   assign bus_quiet_hold = quiet_r;

endmodule

// File: dv/lrp_ctrl_checker.sv
// Concurrent checks on the pins and status outputs of the refresh and low-power controller.
`timescale 1ns/10ps

module lrp_ctrl_checker
   import lrp_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Status.
   input wire logic in_low_power,
   input wire logic refresh_pulse,
   input wire logic needs_init,
   input wire logic bus_quiet_hold,
   // Device pins.
   input wire logic ck,
   input wire logic complement_clock,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ADDR_W-1:0] addr
);
   // ====
   // Helper logic
   // ====
   // Command code on the pins and its no-operation decode.
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire logic quiet_cmd = cs_n | (cmd == CMD_NOP);
   logic self_r;
   logic [CNT_W-1:0] hold_cnt_r;

   // Remembers a self refresh entry and counts the cycles of the quiet-bus hold.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         self_r <= 1'b0;
         hold_cnt_r <= '0;
      end else begin
         self_r <= (cmd == CMD_REFRESH && !cke) | (self_r & !cke);
         hold_cnt_r <= bus_quiet_hold ? hold_cnt_r + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ====
   // Assertions
   // ====
   property p_refresh_pulse;
      refresh_pulse == (cmd == CMD_REFRESH && cke);
   endproperty
   a_refresh_pulse: assert property (p_refresh_pulse)
      else $error("refresh pulse and refresh command disagree");
   property p_prech_first;
      cmd == CMD_REFRESH |-> $past(cmd) == CMD_PRECHARGE && $past(addr[ALL_BANKS_BIT]);
   endproperty
   a_prech_first: assert property (p_prech_first)
      else $error("refresh not preceded by precharge of all banks");
   property p_refresh_wait;
      cmd == CMD_REFRESH && cke |=> (quiet_cmd && cke) [*2];
   endproperty
   a_refresh_wait: assert property (p_refresh_wait)
      else $error("command or low clock enable inside refresh cycle");
   property p_mode_deselect;
      !cke && $past(cke) == 1'b0 |-> cs_n;
   endproperty
   a_mode_deselect: assert property (p_mode_deselect)
      else $error("device selected while clock enable low");
   property p_self_exit;
      $rose(cke) && self_r |-> quiet_cmd [*3];
   endproperty
   a_self_exit: assert property (p_self_exit)
      else $error("self refresh exit wait too short");
   property p_wake_nop;
      $rose(cke) |-> quiet_cmd;
   endproperty
   a_wake_nop: assert property (p_wake_nop)
      else $error("clock enable raised without no-operation");
   property p_deep_entry;
      cmd == CMD_DEEP_SLEEP |-> !cke ##[0:2] needs_init;
   endproperty
   a_deep_entry: assert property (p_deep_entry)
      else $error("deep sleep entry wrong or init flag missing");
   property p_clock_stop;
      in_low_power && $past(in_low_power) && cke |-> !ck && complement_clock;
   endproperty
   a_clock_stop: assert property (p_clock_stop)
      else $error("clock not parked during clock stop");
   property p_quiet_hold;
      $fell(bus_quiet_hold) |-> hold_cnt_r >= QUIET_CYCLES - 1;
   endproperty
   a_quiet_hold: assert property (p_quiet_hold)
      else $error("quiet bus hold ended early");
   property p_restart_nop;
      $fell(in_low_power) && $past(cke) |-> quiet_cmd [*3];
   endproperty
   a_restart_nop: assert property (p_restart_nop)
      else $error("command too soon after clock restart");
   property p_ck_toggle;
      rst_n && $past(rst_n) && !in_low_power && !$past(in_low_power) |-> ck != $past(ck);
   endproperty
   a_ck_toggle: assert property (p_ck_toggle)
      else $error("device clock not running outside low-power modes");
endmodule

// File: dv/lrp_dev_model.sv
// Behavioural model of the low-power DRAM as seen at its command pins.
`timescale 1ns/10ps

module lrp_dev_model
   import lrp_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Device pins.
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   // Model status: 0 idle, 1 self refresh, 2 power-down, 3 deep sleep.
   output logic [2:0] dev_state,
   output logic data_lost,
   output int n_viol
);
   // Command code and no-operation decode; address pins are ignored.
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire logic is_nop = cs_n | (cmd == CMD_NOP);
   int rfc_cnt;

   // Registers a command at each rising edge and tracks the device mode.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_state <= 3'h0;
         data_lost <= 1'b0;
         n_viol <= 0;
         rfc_cnt <= 0;
      end else begin
         if (rfc_cnt > 0) begin
            rfc_cnt <= rfc_cnt - 1;
            n_viol <= n_viol + ((!is_nop || !cke) ? 1 : 0);
         end
         if (dev_state == 3'h0) begin
            if (cmd == CMD_REFRESH && cke) begin
               rfc_cnt <= RFC_CYC;
            end else if (cmd == CMD_REFRESH) begin
               dev_state <= 3'h1;
            end else if (cmd == CMD_DEEP_SLEEP && !cke) begin
               dev_state <= 3'h3;
               data_lost <= 1'b1;
            end else if (!cke) begin
               dev_state <= 3'h2;
            end
         end else if (cke) begin
            dev_state <= 3'h0;
            n_viol <= n_viol + (is_nop ? 0 : 1);
         end
      end
   end
endmodule

// File: dv/lpddr_refresh_power_states_tb_top.sv
// Testbench top for the refresh and low-power controller with a device model.
`timescale 1ns/10ps

module lpddr_refresh_power_states_tb_top
   import lrp_pkg::*;
;
   localparam int QUIET_CYCLES = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] mode_req = 3'h0;
   logic wake_req = 1'b0;
   logic access_busy = 1'b0;
   logic idle, in_low_power, refresh_pulse, needs_init, bus_quiet_hold;
   logic ck, complement_clock, cke, cs_n, ras_n, cas_n, we_n, data_lost;
   logic [ADDR_W-1:0] addr;
   logic [2:0] dev_state;
   int n_viol;
   int n_mismatch = 0;
   int compares = 0;

   // Controller under test and the device it drives.
   lrp_host_ctrl #(.QUIET_CYCLES(QUIET_CYCLES)) dut (.clk(clk), .rst_n(rst_n), .mode_req(mode_req),
      .wake_req(wake_req), .access_busy(access_busy), .idle(idle), .in_low_power(in_low_power),
      .refresh_pulse(refresh_pulse), .needs_init(needs_init), .bus_quiet_hold(bus_quiet_hold), .ck(ck),
      .complement_clock(complement_clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .addr(addr));
   lrp_dev_model u_dev (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .dev_state(dev_state), .data_lost(data_lost), .n_viol(n_viol));

   // Clock generator.
   initial begin
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   // Compares a seen value with the expected one and counts both.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Waits a bounded time for the low-power status to reach a level.
   task automatic wait_lp(input logic want);
      for (int i = 0; i < 400 && in_low_power !== want; i++) @(negedge clk);
      check("in_low_power", in_low_power, want);
   endtask

   // Waits a bounded time for a refresh pulse and returns the cycles spent.
   task automatic wait_ref(input int limit, output int n);
      for (n = 0; n < limit && refresh_pulse !== 1'b1; n++) @(negedge clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Periodic refresh: pins, clock enable and spacing.
   task automatic t_refresh();
      int n;
      wait_ref(300, n);
      check("refresh_cmd", {cs_n, ras_n, cas_n, we_n, cke}, {CMD_REFRESH, 1'b1});
      @(negedge clk);
      wait_ref(REFI_CYC + 20, n);
      check("refresh_gap", {refresh_pulse, n < REFI_CYC}, 2'b11);
      $display("t_refresh done");
   endtask

   // Self refresh entry, stay and exit with the forced refresh.
   task automatic t_self();
      int n;
      mode_req = 3'h1;
      wait_lp(1'b1);
      mode_req = 3'h0;
      repeat (20) @(negedge clk);
      check("self_state", {cke, idle, dev_state}, {2'b00, 3'h1});
      wake_req = 1'b1;
      wait_lp(1'b0);
      wake_req = 1'b0;
      wait_ref(20, n);
      check("self_exit_refresh", refresh_pulse, 1'b1);
      $display("t_self done");
   endtask

   // Power-down held off by a column access, then cut short by refresh.
   task automatic t_pd();
      int n;
      access_busy = 1'b1;
      mode_req = 3'h2;
      repeat (30) @(negedge clk);
      check("busy_blocks", {cke, in_low_power}, 2'b10);
      access_busy = 1'b0;
      wait_lp(1'b1);
      mode_req = 3'h0;
      repeat (3) @(negedge clk);
      check("pd_state", {cke, dev_state}, {1'b0, 3'h2});
      wait_ref(REFI_CYC + 20, n);
      check("pd_refresh", refresh_pulse, 1'b1);
      $display("t_pd done");
   endtask

   // Deep sleep entry, exit, init flag and quiet-bus hold.
   task automatic t_deep();
      mode_req = 3'h3;
      wait_lp(1'b1);
      mode_req = 3'h0;
      repeat (3) @(negedge clk);
      check("deep_state", {needs_init, data_lost, dev_state}, {2'b11, 3'h3});
      wake_req = 1'b1;
      wait_lp(1'b0);
      repeat (2) @(negedge clk);
      check("quiet_hold", {bus_quiet_hold, needs_init}, 2'b11);
      wake_req = 1'b0;
      repeat (QUIET_CYCLES + 10) @(negedge clk);
      check("quiet_done", {bus_quiet_hold, needs_init}, 2'b00);
      $display("t_deep done");
   endtask

   // Clock stop: parked clock levels, then restart.
   task automatic t_clkstop();
      mode_req = 3'h4;
      wait_lp(1'b1);
      mode_req = 3'h0;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         check("clock_stop", {ck, complement_clock, cke}, 3'b011);
         @(negedge clk);
      end
      wake_req = 1'b1;
      wait_lp(1'b0);
      wake_req = 1'b0;
      repeat (4) @(negedge clk);
      check("model_violations", n_viol, 0);
      check("idle_after_restart", idle, 1'b1);
      $display("t_clkstop done");
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_refresh();
      t_self();
      t_pd();
      t_deep();
      t_clkstop();
      complete_run();
   end

   // Watchdog against a hang.
   initial begin
      #(CLK_PERIOD_NS * 5000);
      n_mismatch++;
      $display("Error watchdog expected done seen hang");
      complete_run();
   end
endmodule

bind lrp_host_ctrl lrp_ctrl_checker #(.QUIET_CYCLES(QUIET_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
   .in_low_power(in_low_power), .refresh_pulse(refresh_pulse), .needs_init(needs_init),
   .bus_quiet_hold(bus_quiet_hold), .ck(ck), .complement_clock(complement_clock), .cke(cke),
   .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr));
